// ==== core/pic_top.sv ====
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"

module pic_top
    import pic_pkg::*;
#(
    parameter int NSRC = `PIC_NUM_SRC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // CPU core status
    input  wire logic        instrLastCycle,
    input  wire logic        instrBlocking,
    input  wire logic        instrReturn,
    // External request pins, active low
    input  wire logic        ext0PinN,
    input  wire logic        ext1PinN,
    // Peripheral events, one-cycle pulses, plus the timer 0 mode 3 level
    input  wire logic        timer0Rollover,
    input  wire logic        timer1Rollover,
    input  wire logic        timer0Mode3,
    input  wire logic        uartRxDoneSet,
    input  wire logic        uartTxDoneSet,
    input  wire logic        spiDoneSet,
    input  wire logic        comparatorEventSet,
    // Long call to the core
    output logic             callStart,
    output logic             callActive,
    output logic      [15:0] callVector,
    output logic      [3:0]  serviceLevels
);
    localparam int POS [NSRC] = '{`PIC_POS_EXT0, `PIC_POS_TIMER0,
                                  `PIC_POS_EXT1, `PIC_POS_TIMER1,
                                  `PIC_POS_SERIAL, `PIC_POS_COMP};
    localparam logic [15:0] VEC [NSRC] = '{`PIC_VEC_EXT0,
                                           `PIC_VEC_TIMER0,
                                           `PIC_VEC_EXT1,
                                           `PIC_VEC_TIMER1,
                                           `PIC_VEC_SERIAL,
                                           `PIC_VEC_COMP};

    logic [7:0]  enable_reg;
    logic [7:0]  prioHigh_reg;
    logic [7:0]  prioLow_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  ctrl_reg;
    logic [3:0]  inService_reg;
    logic [3:0]  inService_next;
    logic        regTouched_reg;
    logic        regTouched_next;
    pic_state_t  state_reg;
    pic_state_t  state_next;
    logic [1:0]  callCount_reg;
    logic [1:0]  callCount_next;
    logic [15:0] callVector_reg;
    logic        callStart_reg;
    logic        callActive_reg;
    logic        ack_reg;
    logic [31:0] datOut_reg;

    // Bus decode
    wire logic [7:0] busIdx    = wb_adr_i[9:2];
    wire logic       busReq    = wb_cyc_i & wb_stb_i;
    wire logic       busWrite  = busReq & wb_we_i & ack_reg & wb_sel_i[0];
    wire logic [7:0] wrByte    = wb_dat_i[7:0];
    wire logic       hitEnable = busIdx == `PIC_IDX_ENABLE;
    wire logic       hitHigh   = busIdx == `PIC_IDX_PRIO_HIGH;
    wire logic       hitLow    = busIdx == `PIC_IDX_PRIO_LOW;
    wire logic       hitFlags  = busIdx == `PIC_IDX_FLAGS;
    wire logic       hitCtrl   = busIdx == `PIC_IDX_CTRL;
    wire logic       hitStatus = busIdx == `PIC_IDX_STATUS;
    wire logic       wrEnable  = busWrite & hitEnable;
    wire logic       wrHigh    = busWrite & hitHigh;
    wire logic       wrLow     = busWrite & hitLow;
    wire logic       wrFlags   = busWrite & hitFlags;
    wire logic       wrCtrl    = busWrite & hitCtrl;
    wire logic       cfgWrite  = wrEnable | wrHigh | wrLow;

    wire logic [7:0] statusByte = {3'h0, callActive_reg, inService_reg};
    wire logic [7:0] rdByte =
        hitEnable ? enable_reg   :
        hitHigh   ? prioHigh_reg :
        hitLow    ? prioLow_reg  :
        hitFlags  ? flags_reg    :
        hitCtrl   ? ctrl_reg     :
        hitStatus ? statusByte   : 8'h00;

    // External pins
    logic [1:0] extLow;
    logic [1:0] extFall;
    wire logic [1:0] extPinsN = {ext1PinN, ext0PinN};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gExt
            pic_pin_sync u_sync (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .pinN     (extPinsN[g]),
                .pinLow   (extLow[g]),
                .fallEdge (extFall[g])
            );
        end
    endgenerate

    wire logic ext0Edge = ctrl_reg[`PIC_CTL_EXT0_TYPE];
    wire logic ext1Edge = ctrl_reg[`PIC_CTL_EXT1_TYPE];

    // Per-source request, enable and level
    pic_arb_if #(.NSRC(NSRC)) arb ();

    wire logic [NSRC-1:0] srcFlag = {
        flags_reg[`PIC_FLG_COMP],
        flags_reg[`PIC_FLG_UART_RX] | flags_reg[`PIC_FLG_UART_TX] |
            flags_reg[`PIC_FLG_SPI],
        flags_reg[`PIC_FLG_TIMER1],
        flags_reg[`PIC_FLG_EXT1],
        flags_reg[`PIC_FLG_TIMER0],
        flags_reg[`PIC_FLG_EXT0]
    };
    wire logic gate = enable_reg[`PIC_POS_GATE];

    generate
        for (g = 0; g < NSRC; g++) begin : gSrc
            // Flags are registers, so the poll sees last cycle's values
            assign arb.pending[g] = srcFlag[g] & enable_reg[POS[g]] & gate;
            assign arb.level[g]   = {prioHigh_reg[POS[g]],
                                     prioLow_reg[POS[g]]};
        end
    endgenerate

    pic_arbiter #(.NSRC(NSRC)) u_arb (
        .arb (arb)
    );

    // Highest level now in service
    logic       curValid;
    pic_level_t curLevel;
    always_comb begin
        curValid = 1'b0;
        curLevel = '0;
        for (int i = 0; i < 4; i++) begin
            if (inService_reg[i]) begin
                curValid = 1'b1;
                curLevel = pic_level_t'(i);
            end
        end
    end

    wire logic preempt = !curValid || arb.winLevel > curLevel;
    wire logic blocked = instrBlocking | regTouched_reg | cfgWrite;
    // Decided fresh at every poll; nothing of a denial is kept
    wire logic accept  = state_reg == PIC_ST_IDLE & instrLastCycle &
                         arb.winValid & preempt & ~blocked;
    wire logic doReturn = state_reg == PIC_ST_IDLE & instrLastCycle &
                          instrReturn;
    wire pic_src_t win  = arb.winIndex;

    // A config write keeps the poll closed until one more instruction ends
    always_comb begin
        regTouched_next = (regTouched_reg | cfgWrite) & ~instrLastCycle;
    end

    // Request flags: software first, then vectoring clear, then hardware set
    always_comb begin
        flags_next = flags_reg;
        if (wrFlags) begin
            flags_next = wrByte;
            flags_next[`PIC_FLG_SPI] =
                flags_reg[`PIC_FLG_SPI] & wrByte[`PIC_FLG_SPI];
        end
        if (accept) begin
            if (win == `PIC_SRC_TIMER0) begin
                flags_next[`PIC_FLG_TIMER0] = 1'b0;
            end
            if (win == `PIC_SRC_TIMER1) begin
                flags_next[`PIC_FLG_TIMER1] = 1'b0;
            end
            if (win == `PIC_SRC_EXT0 && ext0Edge) begin
                flags_next[`PIC_FLG_EXT0] = 1'b0;
            end
            if (win == `PIC_SRC_EXT1 && ext1Edge) begin
                flags_next[`PIC_FLG_EXT1] = 1'b0;
            end
        end
        // Set beats clear in the same cycle so no event is lost
        if (timer0Rollover && !timer0Mode3) begin
            flags_next[`PIC_FLG_TIMER0] = 1'b1;
        end
        if (timer1Rollover) begin
            flags_next[`PIC_FLG_TIMER1] = 1'b1;
        end
        if (uartRxDoneSet) begin
            flags_next[`PIC_FLG_UART_RX] = 1'b1;
        end
        if (uartTxDoneSet) begin
            flags_next[`PIC_FLG_UART_TX] = 1'b1;
        end
        if (spiDoneSet) begin
            flags_next[`PIC_FLG_SPI] = 1'b1;
        end
        if (comparatorEventSet) begin
            flags_next[`PIC_FLG_COMP] = 1'b1;
        end
        if (ext0Edge) begin
            if (extFall[0]) begin
                flags_next[`PIC_FLG_EXT0] = 1'b1;
            end
        end else begin
            // Level mode: the pin owns the flag, writes do not stick
            flags_next[`PIC_FLG_EXT0] = extLow[0];
        end
        if (ext1Edge) begin
            if (extFall[1]) begin
                flags_next[`PIC_FLG_EXT1] = 1'b1;
            end
        end else begin
            flags_next[`PIC_FLG_EXT1] = extLow[1];
        end
    end

    // In-service levels: push on accept, pop highest on return
    always_comb begin
        inService_next = inService_reg;
        if (doReturn && curValid) begin
            inService_next[curLevel] = 1'b0;
        end
        if (accept) begin
            inService_next[arb.winLevel] = 1'b1;
        end
    end

    // Long call sequencer
    always_comb begin
        state_next     = state_reg;
        callCount_next = callCount_reg;
        case (state_reg)
            PIC_ST_IDLE: begin
                if (accept) begin
                    state_next     = PIC_ST_CALL;
                    callCount_next = `PIC_CALL_CYCLES;
                end
            end
            PIC_ST_CALL: begin
                if (callCount_reg == 2'd0) begin
                    state_next = PIC_ST_IDLE;
                end else begin
                    callCount_next = callCount_reg - 2'd1;
                end
            end
            default: begin
                state_next = PIC_ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            enable_reg   <= `PIC_RST_ENABLE;
            prioHigh_reg <= `PIC_RST_PRIO;
            prioLow_reg  <= `PIC_RST_PRIO;
            ctrl_reg     <= `PIC_RST_CTRL;
        end else begin
            if (wrEnable) begin
                enable_reg <= wrByte & `PIC_MASK_ENABLE;
            end
            if (wrHigh) begin
                prioHigh_reg <= wrByte & `PIC_MASK_PRIO;
            end
            if (wrLow) begin
                prioLow_reg <= wrByte & `PIC_MASK_PRIO;
            end
            if (wrCtrl) begin
                ctrl_reg <= wrByte & `PIC_MASK_CTRL;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flags_reg      <= `PIC_RST_FLAGS;
            inService_reg  <= 4'h0;
            regTouched_reg <= 1'b0;
        end else begin
            flags_reg      <= flags_next;
            inService_reg  <= inService_next;
            regTouched_reg <= regTouched_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg      <= PIC_ST_IDLE;
            callCount_reg  <= 2'd0;
            callVector_reg <= 16'h0000;
            callStart_reg  <= 1'b0;
            callActive_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            callCount_reg  <= callCount_next;
            callStart_reg  <= accept;
            callActive_reg <= state_next == PIC_ST_CALL;
            if (accept) begin
                callVector_reg <= VEC[win];
            end
        end
    end

    // Wishbone answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ack_reg    <= 1'b0;
            datOut_reg <= 32'h00000000;
        end else begin
            ack_reg <= busReq & ~ack_reg;
            if (busReq && !ack_reg) begin
                datOut_reg <= {24'h000000, rdByte};
            end
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = datOut_reg;
    assign callStart     = callStart_reg;
    assign callActive    = callActive_reg;
    assign callVector    = callVector_reg;
    assign serviceLevels = inService_reg;
endmodule

`default_nettype wire

// ==== shared/pic_cfg.svh ====
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// Number of request sources
`define PIC_NUM_SRC        6

// Register indices; the byte address is four times the index
`define PIC_IDX_ENABLE     8'hA8
`define PIC_IDX_PRIO_HIGH  8'hB7
`define PIC_IDX_PRIO_LOW   8'hB8
`define PIC_IDX_FLAGS      8'hC0
`define PIC_IDX_CTRL       8'hC1
`define PIC_IDX_STATUS     8'hC2

// Reset values and implemented bits
`define PIC_RST_ENABLE     8'h00
`define PIC_RST_PRIO       8'h00
`define PIC_RST_FLAGS      8'h00
`define PIC_RST_CTRL       8'h00
`define PIC_MASK_ENABLE    8'hDF
`define PIC_MASK_PRIO      8'h5F
`define PIC_MASK_CTRL      8'h03

// Enable and priority bit positions per source
`define PIC_POS_GATE       7
`define PIC_POS_EXT0       0
`define PIC_POS_TIMER0     1
`define PIC_POS_EXT1       2
`define PIC_POS_TIMER1     3
`define PIC_POS_SERIAL     4
`define PIC_POS_COMP       6

// Request flag register bit positions
`define PIC_FLG_EXT0       0
`define PIC_FLG_TIMER0     1
`define PIC_FLG_EXT1       2
`define PIC_FLG_TIMER1     3
`define PIC_FLG_UART_RX    4
`define PIC_FLG_UART_TX    5
`define PIC_FLG_SPI        6
`define PIC_FLG_COMP       7

// Control register bit positions
`define PIC_CTL_EXT0_TYPE  0
`define PIC_CTL_EXT1_TYPE  1

// Source indices in arbitration order
`define PIC_SRC_EXT0       0
`define PIC_SRC_TIMER0     1
`define PIC_SRC_EXT1       2
`define PIC_SRC_TIMER1     3
`define PIC_SRC_SERIAL     4
`define PIC_SRC_COMP       5

// Vector addresses
`define PIC_VEC_EXT0       16'h0003
`define PIC_VEC_TIMER0     16'h000B
`define PIC_VEC_EXT1       16'h0013
`define PIC_VEC_TIMER1     16'h001B
`define PIC_VEC_SERIAL     16'h0023
`define PIC_VEC_COMP       16'h0033

// Count loaded for the forced long call; the call lasts this many cycles plus one
`define PIC_CALL_CYCLES    2'd3

`endif

// ==== shared/pic_pkg.sv ====
package pic_pkg;

    typedef logic [1:0] pic_level_t;
    typedef logic [2:0] pic_src_t;

    typedef enum logic {
        PIC_ST_IDLE,
        PIC_ST_CALL
    } pic_state_t;

endpackage

// ==== shared/pic_arb_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface pic_arb_if #(
    parameter int NSRC = 6
);
    import pic_pkg::*;

    logic [NSRC-1:0] pending;
    pic_level_t      level [NSRC];
    logic            winValid;
    pic_src_t        winIndex;
    pic_level_t      winLevel;

    modport requester (output pending, output level,
                       input winValid, input winIndex, input winLevel);
    modport resolver  (input pending, input level,
                       output winValid, output winIndex, output winLevel);
endinterface

`default_nettype wire

// ==== core/pic_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pic_pin_sync
    import pic_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Pin, active low
    input  wire logic pinN,
    // Synchronised views
    output logic      pinLow,
    output logic      fallEdge
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pinN;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Only the second and third stages feed logic
    assign pinLow   = ~sync_reg;
    assign fallEdge = prev_reg & ~sync_reg;
endmodule

`default_nettype wire

// ==== core/pic_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

module pic_arbiter
    import pic_pkg::*;
#(
    parameter int NSRC = 6
) (
    // Requests in, winner out
    pic_arb_if.resolver arb
);
    always_comb begin
        arb.winValid = 1'b0;
        arb.winIndex = '0;
        arb.winLevel = '0;
        // Highest index first so a lower vector wins a tie in level
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (arb.pending[i] &&
                (!arb.winValid || arb.level[i] >= arb.winLevel)) begin
                arb.winValid = 1'b1;
                arb.winIndex = pic_src_t'(i);
                arb.winLevel = arb.level[i];
            end
        end
    end
endmodule

`default_nettype wire

// ==== bench/pic_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module pic_assertions #(
    parameter int NSRC = 6
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Bus handshake
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Core status
    input wire logic        instrLastCycle,
    input wire logic        instrBlocking,
    input wire logic        instrReturn,
    // Call outputs
    input wire logic        callStart,
    input wire logic        callActive,
    input wire logic [15:0] callVector,
    input wire logic [3:0]  serviceLevels
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_due_a:
        assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    call_length_a:
        assert property (callStart |-> callActive [*4] ##1 !callActive)
        else $error("call length wrong");
    call_cause_a:
        assert property ($rose(callActive) |-> callStart
            && $past(instrLastCycle) && !$past(instrBlocking))
        else $error("call outside poll");
    vector_legal_a:
        assert property (callStart |-> callVector inside {16'h0003,
            16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h0033})
        else $error("bad vector");
    top_hold_a:
        assert property (serviceLevels[3] |=> !callStart)
        else $error("top level preempted");
    level_up_a:
        assert property (callStart |->
            (serviceLevels & ~$past(serviceLevels)) > $past(serviceLevels))
        else $error("preempt not higher");
    level_change_a:
        assert property ($changed(serviceLevels) |->
            callStart || $past(instrReturn && instrLastCycle))
        else $error("levels changed alone");
    call_gap_a:
        assert property (callStart |=> !callStart [*4])
        else $error("poll during call");

    cover property (callStart && callVector == 16'h001B);
    cover property (serviceLevels[3]);
    cover property (wb_ack_o && wb_cyc_i);
endmodule

bind pic_top pic_assertions #(.NSRC(NSRC)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .instrLastCycle(instrLastCycle), .instrBlocking(instrBlocking),
    .instrReturn(instrReturn), .callStart(callStart),
    .callActive(callActive), .callVector(callVector),
    .serviceLevels(serviceLevels));

`default_nettype wire

// ==== bench/pic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pic_core_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Return request and call status
    input  wire logic retReq,
    input  wire logic callActive,
    // Core status
    output logic      instrLastCycle,
    output logic      instrBlocking,
    output logic      instrReturn
);
    logic cntReg;
    logic retReg;

    // Two-cycle instructions; frozen while a call runs
    assign instrLastCycle = cntReg && !callActive;
    assign instrReturn    = retReg;
    assign instrBlocking  = retReg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cntReg <= 1'b0;
            retReg <= 1'b0;
        end else if (!callActive) begin
            cntReg <= !cntReg;
            if (cntReg) begin
                retReg <= retReq;
            end
        end
    end
endmodule

`default_nettype wire

// ==== bench/pic_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"

module pic_top_tb_top;
    logic        sys_clk, resetn, wbCyc, wbStb, wbWe, wbAck, retReq;
    logic        ext0N, ext1N, t0Roll, t0Mode3, txSet, spiSet;
    logic        t1Roll, rxSet, cmpSet;
    logic [3:0]  wbSel;
    logic        lastCyc, blocking, isReturn, callStart, callActive;
    logic [9:0]  wbAdr;
    logic [31:0] wbDatI, wbDatO;
    logic [15:0] callVector;
    logic [3:0]  serviceLevels;
    int          mismatches, checks;
    localparam logic [7:0]  FLG [6] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                        8'h10, 8'h80};
    localparam logic [7:0]  LFT [6] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                        8'h10, 8'h80};
    localparam logic [15:0] VEC [6] = '{`PIC_VEC_EXT0, `PIC_VEC_TIMER0,
        `PIC_VEC_EXT1, `PIC_VEC_TIMER1, `PIC_VEC_SERIAL, `PIC_VEC_COMP};

    pic_top u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .instrLastCycle(lastCyc),
        .instrBlocking(blocking), .instrReturn(isReturn),
        .ext0PinN(ext0N), .ext1PinN(ext1N), .timer0Rollover(t0Roll),
        .timer1Rollover(t1Roll), .timer0Mode3(t0Mode3),
        .uartRxDoneSet(rxSet), .uartTxDoneSet(txSet),
        .spiDoneSet(spiSet), .comparatorEventSet(cmpSet),
        .callStart(callStart), .callActive(callActive),
        .callVector(callVector), .serviceLevels(serviceLevels));

    pic_core_model u_core (
        .sys_clk(sys_clk), .resetn(resetn), .retReq(retReq),
        .callActive(callActive), .instrLastCycle(lastCyc),
        .instrBlocking(blocking), .instrReturn(isReturn));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task results;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Classic cycle; ack is sampled at the edge, never assumed
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
             output logic [31:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        // A bus that never answers is a failure, not a silent skip
        if (wbAck !== 1'b1) begin
            mismatches++;
        end
        rd = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'b000;
        @(posedge sys_clk);
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 8'h00, x);
        check(x, exp);
    endtask

    task wcall(input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (callStart !== 1'b1 && n < 40);
        check({callStart, callActive, callVector}, {2'b11, v});
    endtask

    task nocall(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            check(callStart, 1'b0);
        end
    endtask

    // Held two cycles so exactly one instruction becomes the return
    task ret;
        repeat (4) @(posedge sys_clk);
        retReq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        retReq <= 1'b0;
    endtask

    task t_regs;
        rdchk(`PIC_IDX_ENABLE, 32'h0);
        rdchk(`PIC_IDX_PRIO_HIGH, 32'h0);
        rdchk(`PIC_IDX_PRIO_LOW, 32'h0);
        wr(`PIC_IDX_PRIO_LOW, 8'hFF);
        rdchk(`PIC_IDX_PRIO_LOW, 32'h5F);
        wbSel <= 4'h0;
        wr(`PIC_IDX_PRIO_LOW, 8'h00);
        wbSel <= 4'h1;
        rdchk(`PIC_IDX_PRIO_LOW, 32'h5F);
        wr(`PIC_IDX_PRIO_LOW, 8'h00);
        rdchk(8'h10, 32'h0);
    endtask

    task t_vectors;
        wr(`PIC_IDX_CTRL, 8'h03);
        wr(`PIC_IDX_ENABLE, 8'hDF);
        for (int i = 0; i < 6; i++) begin
            wr(`PIC_IDX_FLAGS, FLG[i]);
            wcall(VEC[i]);
            rdchk(`PIC_IDX_FLAGS, LFT[i]);
            wr(`PIC_IDX_FLAGS, 8'h00);
            ret;
        end
    endtask

    task t_spi;
        wr(`PIC_IDX_FLAGS, 8'h40);
        rdchk(`PIC_IDX_FLAGS, 32'h0);
        {spiSet, txSet, rxSet, cmpSet} <= 4'hF;
        @(posedge sys_clk);
        {spiSet, txSet, rxSet, cmpSet} <= 4'h0;
        wcall(`PIC_VEC_SERIAL);
        rdchk(`PIC_IDX_FLAGS, 32'hF0);
        wr(`PIC_IDX_FLAGS, 8'h80);
        rdchk(`PIC_IDX_FLAGS, 32'h80);
        ret;
        wcall(`PIC_VEC_COMP);
        rdchk(`PIC_IDX_FLAGS, 32'h80);
        wr(`PIC_IDX_FLAGS, 8'h00);
        ret;
    endtask

    task t_prio;
        wr(`PIC_IDX_PRIO_HIGH, 8'h08);
        wr(`PIC_IDX_PRIO_LOW, 8'h08);
        wr(`PIC_IDX_FLAGS, 8'h09);
        wcall(`PIC_VEC_TIMER1);
        check(serviceLevels, 4'h8);
        nocall(12);
        ret;
        wcall(`PIC_VEC_EXT0);
        check(serviceLevels, 4'h1);
        ret;
        wr(`PIC_IDX_PRIO_HIGH, 8'h00);
        wr(`PIC_IDX_PRIO_LOW, 8'h00);
        wr(`PIC_IDX_FLAGS, 8'h09);
        wcall(`PIC_VEC_EXT0);
        nocall(12);
        ret;
        wcall(`PIC_VEC_TIMER1);
        ret;
    endtask

    task t_gate;
        wr(`PIC_IDX_ENABLE, 8'h5F);
        wr(`PIC_IDX_FLAGS, 8'h02);
        nocall(16);
        wr(`PIC_IDX_FLAGS, 8'h00);
        wr(`PIC_IDX_ENABLE, 8'hDF);
        nocall(16);
        t0Roll <= 1'b1;
        @(posedge sys_clk);
        t0Roll <= 1'b0;
        wcall(`PIC_VEC_TIMER0);
        ret;
        t0Mode3 <= 1'b1;
        t0Roll <= 1'b1;
        @(posedge sys_clk);
        t0Roll <= 1'b0;
        rdchk(`PIC_IDX_FLAGS, 32'h0);
        t0Mode3 <= 1'b0;
        t1Roll <= 1'b1;
        @(posedge sys_clk);
        t1Roll <= 1'b0;
        wcall(`PIC_VEC_TIMER1);
        rdchk(`PIC_IDX_FLAGS, 32'h0);
        ret;
    endtask

    task t_ext;
        wr(`PIC_IDX_CTRL, 8'h01);
        ext0N <= 1'b0;
        wcall(`PIC_VEC_EXT0);
        rdchk(`PIC_IDX_FLAGS, 32'h0);
        ext0N <= 1'b1;
        ret;
        ext1N <= 1'b0;
        wcall(`PIC_VEC_EXT1);
        rdchk(`PIC_IDX_FLAGS, 32'h04);
        ext1N <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rdchk(`PIC_IDX_FLAGS, 32'h0);
        ret;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results;
    end

    initial begin
        {resetn, wbCyc, wbStb, wbWe, retReq} <= '0;
        {t0Roll, t0Mode3, txSet, spiSet} <= '0;
        {t1Roll, rxSet, cmpSet} <= '0;
        wbSel <= 4'h1;
        {ext0N, ext1N} <= 2'b11;
        wbAdr <= '0;
        wbDatI <= '0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs;
        t_vectors;
        t_spi;
        t_prio;
        t_gate;
        t_ext;
        results;
    end
endmodule

`default_nettype wire
